// ==== design/drive_flags_pkg.sv ====
// Package of constants, register map and carrier types for the drive status flag block
package drive_flags_pkg;

  // -------------------------------------------------------------------------
  // Bus and register map
  // -------------------------------------------------------------------------
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam logic [11:0] OFS_CONTROL       = 12'h000;
  localparam logic [11:0] OFS_HOUR_LIMIT    = 12'h004;
  localparam logic [11:0] OFS_THERM_SET     = 12'h008;
  localparam logic [11:0] OFS_THERM_CURVE   = 12'h00c;
  localparam logic [11:0] OFS_WARN_LEVEL    = 12'h010;
  localparam logic [11:0] OFS_FREE_PT0      = 12'h014;
  localparam logic [11:0] OFS_FREE_PT1      = 12'h018;
  localparam logic [11:0] OFS_FREE_PT2      = 12'h01c;
  localparam logic [11:0] OFS_SPEED_THR     = 12'h020;
  localparam logic [11:0] OFS_BRAKE_CUR     = 12'h024;
  localparam logic [11:0] OFS_STATUS        = 12'h028;
  localparam logic [11:0] OFS_RUN_HOURS     = 12'h02c;
  localparam logic [11:0] OFS_POWER_HOURS   = 12'h030;
  localparam logic [11:0] OFS_THERM_ACC     = 12'h034;

  // Control register bits
  localparam int CTL_BRAKE_EN = 0;
  localparam int CTL_PROF_LSB = 1;

  // -------------------------------------------------------------------------
  // Thermal scaling: currents in 1/10 A, setting in 1/100 of rated
  // -------------------------------------------------------------------------
  localparam logic [7:0]  SET_MIN_PCT       = 8'h14;   // 0.2 x rated
  localparam logic [7:0]  SET_MAX_PCT       = 8'h78;   // 1.2 x rated
  localparam logic [7:0]  PCT_FULL          = 8'h64;   // 100 percent
  localparam logic [15:0] FREQ_MAX          = 16'h0190; // 400 Hz
  localparam logic [15:0] CUR_MAX           = 16'h2710; // 1000.0 A
  localparam logic [15:0] FREQ_REDUCED_KNEE = 16'h00c8; // 20.0 Hz in 1/10 Hz
  localparam logic [15:0] FREQ_CONST_KNEE   = 16'h0019; // 2.5 Hz in 1/10 Hz
  localparam logic [7:0]  FACT_REDUCED      = 8'h50;   // 0.8
  localparam logic [7:0]  FACT_CONST        = 8'h5a;   // 0.9
  localparam logic [1:0]  CURVE_REDUCED     = 2'h0;
  localparam logic [1:0]  CURVE_CONST       = 2'h1;
  localparam int          NUM_PROFILES      = 3;
  localparam int          NUM_FREE_PTS      = 3;

  // -------------------------------------------------------------------------
  // Hour timing
  // -------------------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int HOUR_S         = 3600;
  localparam longint HOUR_CYCLES = longint'(CLK_HZ) * longint'(HOUR_S);

  typedef struct packed {
    logic [15:0] freq;   // Hz
    logic [15:0] cur;    // 1/10 A, zero disables the point
  } free_point_type;

  typedef struct packed {
    logic        torque_limit_flag;
    logic        run_hours_over;
    logic        power_hours_over;
    logic        thermal_warning;
    logic        brake_release_out;
    logic        brake_fault_out;
    logic        zero_speed_flag;
    logic        speed_error_flag;
    logic        position_done_flag;
  } flags_type;

  typedef struct packed {
    logic [15:0] current;      // 1/10 A
    logic [15:0] freq;         // 1/10 Hz
    logic [15:0] torque;
    logic [15:0] torque_lim;
    logic        running;
    logic        driving;
  } drive_meas_type;

endpackage

// ==== design/drive_status_output_flags.sv ====
// Status flag logic of a motor drive: torque, hours, thermal, brake and encoder flags
// Operation
// - Torque flag high while limiting; falls by itself below the limit.
// - Torque flag only while the torque limit enable input is on.
// - Two hour counters: run-mode hours and powered hours.
// - Run-hours-over once run hours exceed the hour limit.
// - Power-hours-over once powered hours exceed the hour limit.
// - Both hour comparisons share one hour limit.
// - Thermal model integrates current squared over time.
// - Thermal warning at warn level percent (0 to 100) of trip level.
// - Three motor profiles each keep their own thermal setting and curve; all share one thermal level.
// - Thermal setting limited on write to 0.2 to 1.2 of rated current; reset loads 0.
// - Curve select: 00 reduced torque, others constant or free-setting.
// - Reduced torque curve: trip current 0.8 at 20 Hz.
// - Constant torque curve: trip current 0.9 at 2.5 Hz.
// - Free curve of three points; zero current disables a point.
// - Brake release high only while driving the motor.
// - Brake fault when current is below the releasing current.
// - Brake fault low when brake unused or current correct.
// - Release needs an active high level; open line engages brake.
// - Zero speed flag when encoder pulses have stopped.
// - Speed error flag when velocity error exceeds its threshold.
// - Position done flag when load position equals target.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module drive_status_output_flags
  import drive_flags_pkg::*;
#(
  parameter longint HOUR_TICKS     = HOUR_CYCLES,
  parameter int     ZS_IDLE_CYC    = 1_000_000,
  parameter int     RATED_CUR      = 16'd460
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                torque_limit_enable_in,
  input  wire logic                enc_pulse_in,
  input  wire drive_meas_type      meas,
  input  wire logic signed [15:0]  speed_ref,
  input  wire logic signed [15:0]  speed_fb,
  input  wire logic [31:0]         target_pos,
  input  wire logic [31:0]         load_pos,
  output flags_type                flags
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0]  rdata;
    logic               ready;
    logic               slverr;
    logic               brake_en;
    logic [1:0]         profile;
    logic [31:0]        hour_limit;
    logic [2:0][7:0]    therm_set;
    logic [2:0][1:0]    therm_curve;
    logic [7:0]         warn_level;
    free_point_type [2:0] free_pt;
    logic [15:0]        speed_thr;
    logic [15:0]        brake_cur;
    logic [43:0]        run_tick;
    logic [43:0]        pwr_tick;
    logic [31:0]        run_hours;
    logic [31:0]        power_hours;
    logic [47:0]        therm_acc;
    logic [2:0]         enc_sync;
    logic               enc_stable;
    logic [31:0]        idle_cnt;
    flags_type          flg;
  } state_type;

  state_type st;
  state_type next_st;

  // -------------------------------------------------------------------------
  // Thermal trip derivation
  // -------------------------------------------------------------------------
  logic [7:0]  set_pct;
  logic [1:0]  curve;
  logic [7:0]  derate;
  logic [15:0] trip_cur;
  logic [31:0] trip_sq;
  logic [47:0] trip_acc;
  logic [47:0] warn_acc;
  logic [31:0] cur_sq;
  logic [15:0] free_cur;
  logic [15:0] speed_err;
  logic        apb_acc;
  logic        wr;
  logic [1:0]  pidx;

  always_comb begin
    pidx = (st.profile < 2'(NUM_PROFILES)) ? st.profile : 2'h0;
    set_pct = st.therm_set[pidx];
    curve = st.therm_curve[pidx];
    free_cur = 16'h0;
    for (int i = NUM_FREE_PTS - 1; i >= 0; i--) begin
      if (st.free_pt[i].cur != 16'h0 &&
          meas.freq <= 16'(st.free_pt[i].freq * 16'd10)) begin
        free_cur = st.free_pt[i].cur;
      end
    end
    derate = PCT_FULL;
    if (curve == CURVE_REDUCED && meas.freq <= FREQ_REDUCED_KNEE) begin
      derate = FACT_REDUCED;
    end else if (curve == CURVE_CONST && meas.freq <= FREQ_CONST_KNEE) begin
      derate = FACT_CONST;
    end
    trip_cur = 16'((32'(RATED_CUR) * 32'(set_pct) * 32'(derate)) / 32'd10000);
    if (curve != CURVE_REDUCED && curve != CURVE_CONST && free_cur != 16'h0) begin
      trip_cur = free_cur;
    end
    trip_sq  = 32'(trip_cur) * 32'(trip_cur);
    trip_acc = {trip_sq, 16'h0};
    warn_acc = 48'((64'(trip_acc) * 64'(st.warn_level)) / 64'(PCT_FULL));
    cur_sq   = 32'(meas.current) * 32'(meas.current);
    speed_err = (speed_ref > speed_fb) ? 16'(speed_ref - speed_fb)
                                       : 16'(speed_fb - speed_ref);
    apb_acc  = psel && penable;
    wr       = apb_acc && pwrite;
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // APB slave: one wait state, answer in the cycle after the access phase starts
    next_st.ready  = apb_acc && !st.ready;
    next_st.slverr = 1'b0;
    next_st.rdata  = '0;
    if (apb_acc && !st.ready) begin
      unique case (paddr)
        OFS_CONTROL:     next_st.rdata = {29'h0, st.profile, st.brake_en};
        OFS_HOUR_LIMIT:  next_st.rdata = st.hour_limit;
        OFS_THERM_SET:   next_st.rdata = {24'h0, st.therm_set[pidx]};
        OFS_THERM_CURVE: next_st.rdata = {30'h0, st.therm_curve[pidx]};
        OFS_WARN_LEVEL:  next_st.rdata = {24'h0, st.warn_level};
        OFS_FREE_PT0:    next_st.rdata = st.free_pt[0];
        OFS_FREE_PT1:    next_st.rdata = st.free_pt[1];
        OFS_FREE_PT2:    next_st.rdata = st.free_pt[2];
        OFS_SPEED_THR:   next_st.rdata = {16'h0, st.speed_thr};
        OFS_BRAKE_CUR:   next_st.rdata = {16'h0, st.brake_cur};
        OFS_STATUS:      next_st.rdata = {23'h0, st.flg};
        OFS_RUN_HOURS:   next_st.rdata = st.run_hours;
        OFS_POWER_HOURS: next_st.rdata = st.power_hours;
        OFS_THERM_ACC:   next_st.rdata = st.therm_acc[47:16];
        default:         next_st.slverr = 1'b1;
      endcase
      if (wr) begin
        next_st.rdata = '0;
        unique case (paddr)
          OFS_CONTROL: begin
            next_st.brake_en = pwdata[CTL_BRAKE_EN];
            next_st.profile  = pwdata[CTL_PROF_LSB +: 2];
          end
          OFS_HOUR_LIMIT:  next_st.hour_limit = pwdata;
          OFS_THERM_SET: begin
            if (pwdata[7:0] < SET_MIN_PCT) next_st.therm_set[pidx] = SET_MIN_PCT;
            else if (pwdata[7:0] > SET_MAX_PCT) next_st.therm_set[pidx] = SET_MAX_PCT;
            else next_st.therm_set[pidx] = pwdata[7:0];
          end
          OFS_THERM_CURVE: next_st.therm_curve[pidx] = pwdata[1:0];
          OFS_WARN_LEVEL:
            next_st.warn_level = (pwdata[7:0] > PCT_FULL) ? PCT_FULL : pwdata[7:0];
          OFS_FREE_PT0, OFS_FREE_PT1, OFS_FREE_PT2: begin
            next_st.free_pt[paddr[3:2] - 2'h1].freq =
              (pwdata[31:16] > FREQ_MAX) ? FREQ_MAX : pwdata[31:16];
            next_st.free_pt[paddr[3:2] - 2'h1].cur =
              (pwdata[15:0] > CUR_MAX) ? CUR_MAX : pwdata[15:0];
          end
          OFS_SPEED_THR:   next_st.speed_thr = pwdata[15:0];
          OFS_BRAKE_CUR:   next_st.brake_cur = pwdata[15:0];
          default:         next_st.slverr = !(paddr inside {OFS_STATUS, OFS_RUN_HOURS,
                                              OFS_POWER_HOURS, OFS_THERM_ACC});
        endcase
      end
    end

    // Hour counters; a tick register wraps each hour
    next_st.pwr_tick = st.pwr_tick + 44'h1;
    if (st.pwr_tick >= 44'(HOUR_TICKS - 1)) begin
      next_st.pwr_tick    = '0;
      next_st.power_hours = st.power_hours + 32'h1;
    end
    if (meas.running) begin
      next_st.run_tick = st.run_tick + 44'h1;
      if (st.run_tick >= 44'(HOUR_TICKS - 1)) begin
        next_st.run_tick  = '0;
        next_st.run_hours = st.run_hours + 32'h1;
      end
    end

    // Thermal integrator: current squared per cycle, cools at the trip level squared
    if (64'(st.therm_acc) + 64'(cur_sq) > 64'(trip_acc) + 64'(trip_sq))
      next_st.therm_acc = trip_acc;
    else if (st.therm_acc + 48'(cur_sq) > 48'(trip_sq))
      next_st.therm_acc = st.therm_acc + 48'(cur_sq) - 48'(trip_sq);
    else
      next_st.therm_acc = '0;

    // Encoder pulse synchroniser, two last stages must agree
    next_st.enc_sync = {st.enc_sync[1:0], enc_pulse_in};
    if (st.enc_sync[2] == st.enc_sync[1]) next_st.enc_stable = st.enc_sync[2];
    if (next_st.enc_stable != st.enc_stable) next_st.idle_cnt = '0;
    else if (st.idle_cnt < 32'(ZS_IDLE_CYC)) next_st.idle_cnt = st.idle_cnt + 32'h1;

    // Flags
    next_st.flg.torque_limit_flag = torque_limit_enable_in &&
                                    (meas.torque >= meas.torque_lim);
    next_st.flg.run_hours_over   = st.run_hours > st.hour_limit;
    next_st.flg.power_hours_over = st.power_hours > st.hour_limit;
    next_st.flg.thermal_warning  = st.therm_acc >= warn_acc;
    // Active high release so that a broken line leaves the brake holding
    next_st.flg.brake_release_out = st.brake_en && meas.driving &&
                                    meas.current >= st.brake_cur;
    next_st.flg.brake_fault_out = st.brake_en && meas.driving &&
                                  meas.current < st.brake_cur;
    next_st.flg.zero_speed_flag  = st.idle_cnt >= 32'(ZS_IDLE_CYC);
    next_st.flg.speed_error_flag = speed_err > st.speed_thr;
    next_st.flg.position_done_flag = load_pos == target_pos;
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.rdata;
  assign pready  = st.ready;
  assign pslverr = st.slverr;
  assign flags   = st.flg;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_torque_flag_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(torque_limit_enable_in) |-> !flags.torque_limit_flag)
    else $error("torque flag without enable");
  a_torque_flag_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(torque_limit_enable_in) && $past(meas.torque) < $past(meas.torque_lim))
      |-> !flags.torque_limit_flag)
    else $error("torque flag stuck");
  a_run_hours_cmp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(st.run_hours) > $past(st.hour_limit)) |-> flags.run_hours_over)
    else $error("run hours over missed");
  a_power_hours_cmp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(st.power_hours) <= $past(st.hour_limit)) |-> !flags.power_hours_over)
    else $error("power hours over early");
  a_hours_monotone: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st.power_hours >= $past(st.power_hours))
    else $error("power hours decreased");
  a_brake_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(meas.driving) |-> !flags.brake_release_out && !flags.brake_fault_out)
    else $error("brake released while idle");
  a_brake_exclusive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(flags.brake_release_out && flags.brake_fault_out))
    else $error("brake release and fault together");
  a_position_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(load_pos) == $past(target_pos)) |-> flags.position_done_flag)
    else $error("position done missed");
  a_apb_ready_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held two cycles");

  a_apb_err_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");

  a_apb_rdata_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pready |-> (prdata == '0))
    else $error("read data outside answer");

  // -------------------------------------------------------------------------
  // Flag checks
  // -------------------------------------------------------------------------
  a_flags_reset: assert property (@(posedge clk_sys)
    sys_rst |=> (flags == '0))
    else $error("flags not cleared by reset");

  a_power_hours_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(st.power_hours) > $past(st.hour_limit)) |-> flags.power_hours_over)
    else $error("power hours over missed");

  a_run_hours_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(meas.running) |-> (st.run_hours == $past(st.run_hours)))
    else $error("run hours moved while stopped");

  a_run_hours_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.run_hours == $past(st.run_hours)) || (st.run_hours == $past(st.run_hours) + 32'h1))
    else $error("run hours jumped");

  a_power_hours_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st.power_hours == $past(st.power_hours)) ||
    (st.power_hours == $past(st.power_hours) + 32'h1))
    else $error("power hours jumped");

  a_warn_level_cap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st.warn_level <= PCT_FULL)
    else $error("warn level above full scale");

  a_fault_low_cur: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags.brake_fault_out |-> ($past(meas.current) < $past(st.brake_cur)))
    else $error("brake fault with enough current");

  a_fault_unused: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(st.brake_en) |-> !flags.brake_fault_out)
    else $error("brake fault while unused");

  // Release only follows an active request, never a default level
  a_release_active: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags.brake_release_out |-> $past(st.brake_en && meas.driving))
    else $error("brake released without request");

  a_zero_speed_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags.zero_speed_flag |-> ($past(st.idle_cnt) >= 32'(ZS_IDLE_CYC)))
    else $error("zero speed while pulses seen");

  a_speed_err_equal: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(speed_ref) == $past(speed_fb)) |-> !flags.speed_error_flag)
    else $error("speed error with no deviation");

  a_speed_err_over: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(speed_err > st.speed_thr) |-> flags.speed_error_flag)
    else $error("speed error missed");

  a_position_away: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(load_pos) != $past(target_pos)) |-> !flags.position_done_flag)
    else $error("position done while away");

endmodule

// ==== test/brake_relay_model.sv ====
// External brake, relays and indicator lamps driven by the status flags
`timescale 1ns/1ns
module brake_relay_model
  import drive_flags_pkg::*;
(
  input  wire flags_type flags,
  output logic           brake_engaged,
  output logic [8:0]     lamp_on
);
  // ---------------------------------------------------------------------------
  // Brake gear
  // ---------------------------------------------------------------------------
  // Only a clean high opens the brake; a floating or unknown line holds the load
  assign brake_engaged = (flags.brake_release_out !== 1'b1);
  assign lamp_on       = flags;
endmodule

// ==== test/drive_status_output_flags_test.sv ====
// Self-checking testbench of the drive status flag block
`timescale 1ns/1ns
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD %s exp %h got %h", name, exp, got); end end
module drive_status_output_flags_test;
  import drive_flags_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, rd_err, brake_engaged;
  logic torque_limit_enable_in = 1'b0, enc_pulse_in = 1'b0;
  drive_meas_type meas = '0;
  logic signed [15:0] speed_ref = '0, speed_fb = '0;
  logic [31:0] target_pos = 32'h0000_0001, load_pos = '0;
  flags_type flags;
  logic [8:0] lamp_on;
  int err_total = 0, checks = 0, cyc = 0;

  // Short hour and idle counts keep the run brief
  drive_status_output_flags #(.HOUR_TICKS(10), .ZS_IDLE_CYC(8), .RATED_CUR(460)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .torque_limit_enable_in(torque_limit_enable_in), .enc_pulse_in(enc_pulse_in),
    .meas(meas), .speed_ref(speed_ref), .speed_fb(speed_fb), .target_pos(target_pos),
    .load_pos(load_pos), .flags(flags));
  brake_relay_model u_brake (.flags(flags), .brake_engaged(brake_engaged), .lamp_on(lamp_on));

  // ---------------------------------------------------------------------------
  // Clock, timeout and closing
  // ---------------------------------------------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Bus and timing helpers
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_chk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, OFS_CONTROL, '0);
    `CHK("control reset", 32'h0, rd)
    apb(1'b1, OFS_HOUR_LIMIT, 32'h2);
    apb(1'b0, OFS_HOUR_LIMIT, '0);
    `CHK("hour limit", 32'h2, rd)
    apb(1'b0, 12'h100, '0);
    `CHK("unmapped error", 1'b1, rd_err)
  endtask
  task automatic t_torque();
    @(posedge clk_sys);
    meas.torque <= 16'h0064; meas.torque_lim <= 16'h0032;
    wait_chk(2);
    `CHK("torque flag disabled", 1'b0, flags.torque_limit_flag)
    @(posedge clk_sys);
    torque_limit_enable_in <= 1'b1;
    wait_chk(2);
    `CHK("torque flag limiting", 1'b1, flags.torque_limit_flag)
    @(posedge clk_sys);
    meas.torque <= 16'h0028;
    wait_chk(2);
    `CHK("torque flag released", 1'b0, flags.torque_limit_flag)
  endtask
  task automatic t_hours();
    wait_chk(40);
    `CHK("power hours over", 1'b1, flags.power_hours_over)
    `CHK("run hours idle", 1'b0, flags.run_hours_over)
    @(posedge clk_sys);
    meas.running <= 1'b1;
    wait_chk(25);
    `CHK("run hours at limit", 1'b0, flags.run_hours_over)
    wait_chk(15);
    `CHK("run hours over", 1'b1, flags.run_hours_over)
  endtask
  task automatic t_brake();
    @(posedge clk_sys);
    meas.driving <= 1'b1; meas.current <= 16'h0064;
    wait_chk(2);
    `CHK("release unused", 1'b0, flags.brake_release_out)
    `CHK("fault unused", 1'b0, flags.brake_fault_out)
    apb(1'b1, OFS_BRAKE_CUR, 32'h32);
    apb(1'b1, OFS_CONTROL, 32'h1);
    wait_chk(2);
    `CHK("release ok", 1'b1, flags.brake_release_out)
    `CHK("fault ok", 1'b0, flags.brake_fault_out)
    `CHK("brake opened", 1'b0, brake_engaged)
    @(posedge clk_sys);
    meas.current <= 16'h0014;
    wait_chk(2);
    `CHK("fault low current", 1'b1, flags.brake_fault_out)
    `CHK("brake held", 1'b1, brake_engaged)
    @(posedge clk_sys);
    meas.driving <= 1'b0; meas.current <= 16'h0064;
    wait_chk(2);
    `CHK("release stopped", 1'b0, flags.brake_release_out)
  endtask
  task automatic t_encoder();
    apb(1'b1, OFS_SPEED_THR, 32'ha);
    @(posedge clk_sys);
    speed_ref <= 16'sd100; speed_fb <= 16'sd89; load_pos <= target_pos;
    wait_chk(2);
    `CHK("speed error over", 1'b1, flags.speed_error_flag)
    `CHK("position done", 1'b1, flags.position_done_flag)
    @(posedge clk_sys);
    speed_fb <= 16'sd90; load_pos <= 32'h0000_0002;
    wait_chk(2);
    `CHK("speed error equal", 1'b0, flags.speed_error_flag)
    `CHK("position away", 1'b0, flags.position_done_flag)
    // Each level held four cycles so the last two filter stages agree
    repeat (4) begin
      repeat (4) @(posedge clk_sys);
      enc_pulse_in <= ~enc_pulse_in;
    end
    wait_chk(1);
    `CHK("zero speed moving", 1'b0, flags.zero_speed_flag)
    wait_chk(20);
    `CHK("zero speed stopped", 1'b1, flags.zero_speed_flag)
  endtask
  task automatic t_thermal();
    apb(1'b1, OFS_THERM_SET, 32'h64);
    apb(1'b1, OFS_WARN_LEVEL, 32'h64);
    wait_chk(3);
    `CHK("thermal cold", 1'b0, flags.thermal_warning)
    apb(1'b1, OFS_WARN_LEVEL, 32'h0);
    wait_chk(3);
    `CHK("thermal zero level", 1'b1, flags.thermal_warning)
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    wait_chk(2);
    `CHK("flags in reset", 9'h000, flags)
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_torque();
    t_hours();
    t_brake();
    t_encoder();
    t_thermal();
    close_out();
  end
endmodule
